// ===== design/pcc_pkg.sv
// Overview of operation
// - forty-eight channel registers at 0x80 plus 4m
// - set lock discards later channel writes
// - lock also locks selected generator register
// - only power reset clears locks
// - generator zero never locked
// - channel_on bit gates channel clock
// - bits 3:0 pick source generator
package pcc_pkg;
	localparam int unsigned PCC_NUM_CH = 48;
	localparam int unsigned PCC_NUM_GEN = 16;
	localparam int unsigned PCC_ADDR_W = 12;
	localparam logic [11:0] PCC_CH_BASE = 12'h080;
	localparam logic [11:0] PCC_CH_STRIDE = 12'h004;
	localparam int unsigned PCC_LOCK_BIT = 7;
	localparam int unsigned PCC_ON_BIT = 6;
	localparam int unsigned PCC_SEL_LSB = 0;
	localparam int unsigned PCC_SEL_W = 4;
	localparam logic [7:0] PCC_CH_RESET = 8'h00;
	localparam logic [7:0] PCC_CH_WMASK = 8'hcf;
	localparam logic [3:0] PCC_GEN_UNLOCKABLE = 4'h0;
endpackage

// ===== design/pcc_gen_lock.sv
`timescale 1ns/1ps
// per-generator lock vector built from the locked channels
module pcc_gen_lock
	import pcc_pkg::*;
#(
	parameter int unsigned NUM_CH = PCC_NUM_CH,
	parameter int unsigned NUM_GEN = PCC_NUM_GEN
) (
	input wire logic [NUM_CH-1:0] ch_lock,
	input wire logic [NUM_CH*PCC_SEL_W-1:0] ch_sel,
	output logic [NUM_GEN-1:0] gen_lock
);
	// or-reduce every locked channel onto the generator it selects
	always_comb begin
		gen_lock = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (ch_lock[c]) begin
				gen_lock[ch_sel[c*PCC_SEL_W +: PCC_SEL_W]] = 1'b1;
			end
		end
		gen_lock[PCC_GEN_UNLOCKABLE] = 1'b0;
	end
endmodule // pcc_gen_lock

// ===== design/pcc_channel_ctrl.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module pcc_channel_ctrl
	import pcc_pkg::*;
#(
	parameter int unsigned NUM_CH = PCC_NUM_CH,
	parameter int unsigned NUM_GEN = PCC_NUM_GEN
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic npower_rst,
	input wire logic [PCC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [NUM_CH-1:0] ch_clk_on,
	output logic [NUM_CH*PCC_SEL_W-1:0] ch_source_select,
	output logic [NUM_GEN-1:0] source_control_lock
);
	////////////////////////////////////////////////////////////////////////
	// refuse sizes that the address map or the 4-bit select cannot serve
	if (NUM_CH < 1 || NUM_CH > PCC_NUM_CH) begin : g_bad_ch
		$error("NUM_CH out of range");
	end
	if (NUM_GEN < 2 || NUM_GEN > PCC_NUM_GEN) begin : g_bad_gen
		$error("NUM_GEN out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// address decode, used by write and read paths
	function automatic logic ch_hit(input logic [PCC_ADDR_W-1:0] a, input int unsigned c);
		logic [PCC_ADDR_W-1:0] target;
		target = PCC_CH_BASE + PCC_ADDR_W'(c) * PCC_CH_STRIDE;
		ch_hit = (a == target);
	endfunction

	logic [NUM_CH-1:0] lock_ff, nxt_lock;
	logic [NUM_CH-1:0] on_ff, nxt_on;
	logic [NUM_CH*PCC_SEL_W-1:0] sel_ff, nxt_sel;
	logic [31:0] rdata_ff, nxt_rdata;

	////////////////////////////////////////////////////////////////////////
	// channel fields: writes discarded once locked
	always_comb begin
		nxt_on = on_ff;
		nxt_sel = sel_ff;
		nxt_lock = lock_ff;
		for (int c = 0; c < NUM_CH; c++) begin
			if (reg_wr && ch_hit(reg_addr, c) && !lock_ff[c]) begin
				nxt_on[c] = reg_wdata[PCC_ON_BIT];
				nxt_sel[c*PCC_SEL_W +: PCC_SEL_W] =
					reg_wdata[PCC_SEL_LSB +: PCC_SEL_W];
				nxt_lock[c] = reg_wdata[PCC_LOCK_BIT];
			end
		end
		// system reset spares locked channels, else their generator lock
		// would fall away with the select field; power reset clears all
		for (int c = 0; c < NUM_CH; c++) begin
			if (!npower_rst || (!nrst && !lock_ff[c])) begin
				nxt_on[c] = 1'b0;
				nxt_sel[c*PCC_SEL_W +: PCC_SEL_W] = '0;
			end
		end
	end

	// on/select registers; both resets are folded into the next values
	always_ff @(posedge core_clk) begin
		on_ff <= nxt_on;
		sel_ff <= nxt_sel;
	end

	// lock sits on power reset only, so a system reset cannot release it
	always_ff @(posedge core_clk) begin
		if (!npower_rst) begin
			lock_ff <= '0;
		end else begin
			lock_ff <= nxt_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data one cycle after the strobe, zero elsewhere
	always_comb begin
		logic [7:0] v;
		v = PCC_CH_RESET;
		nxt_rdata = '0;
		if (reg_rd) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (ch_hit(reg_addr, c)) begin
					v = PCC_CH_RESET;
					v[PCC_LOCK_BIT] = lock_ff[c];
					v[PCC_ON_BIT] = on_ff[c];
					v[PCC_SEL_LSB +: PCC_SEL_W] = sel_ff[c*PCC_SEL_W +: PCC_SEL_W];
					nxt_rdata = {24'h000000, v & PCC_CH_WMASK};
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs to clock gates and generator bank
	assign reg_rdata = rdata_ff;
	assign ch_clk_on = on_ff;
	assign ch_source_select = sel_ff;

	pcc_gen_lock #(
		.NUM_CH(NUM_CH),
		.NUM_GEN(NUM_GEN)
	) u_gen_lock (
		.ch_lock(lock_ff),
		.ch_sel(sel_ff),
		.gen_lock(source_control_lock)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	// channel 1 is one of the two channels the bench locks (1 and 2), so these see real traffic
	chk_locked_write_ignored: assert property (@(posedge core_clk)
		(reg_wr && ch_hit(reg_addr, 1) && lock_ff[1] && npower_rst) |=>
			(on_ff[1] == $past(on_ff[1]) && sel_ff[7:4] == $past(sel_ff[7:4])))
		else $error("locked channel changed");

	// a fresh lock freezes itself too
	chk_lock_takes: assert property (@(posedge core_clk)
		(reg_wr && ch_hit(reg_addr, 1) && !lock_ff[1] && npower_rst) |=>
			lock_ff[1] == $past(reg_wdata[PCC_LOCK_BIT]))
		else $error("lock bit not taken");

	// the edge on which power reset acts is excluded by the antecedent
	chk_lock_sticky: assert property (@(posedge core_clk)
		(lock_ff[1] && npower_rst) |=> lock_ff[1])
		else $error("lock released without power reset");

	// system reset alone leaves a locked channel and its generator alone
	chk_lock_through_sysrst: assert property (@(posedge core_clk)
		(!nrst && npower_rst && lock_ff[1]) |=>
			(ch_clk_on[1] == $past(ch_clk_on[1])
			&& ch_source_select[7:4] == $past(ch_source_select[7:4])))
		else $error("system reset disturbed locked channel");

	// power reset returns every field to its reset value
	chk_power_clears: assert property (@(posedge core_clk)
		!npower_rst |=> (lock_ff == '0 && on_ff == '0 && sel_ff == '0))
		else $error("power reset left state behind");

	chk_gen0_unlocked: assert property (@(posedge core_clk)
		!source_control_lock[0])
		else $error("generator zero locked");

	chk_gen_lock_follows: assert property (@(posedge core_clk)
		(lock_ff[1] && sel_ff[7:4] != 4'h0) |-> source_control_lock[sel_ff[7:4]])
		else $error("selected generator not locked");

	// an unlocked write reaches the clock gate and the select lines
	chk_write_lands: assert property (@(posedge core_clk)
		(reg_wr && ch_hit(reg_addr, 1) && !lock_ff[1] && nrst && npower_rst) |=>
			(ch_clk_on[1] == $past(reg_wdata[PCC_ON_BIT])
			&& ch_source_select[7:4] == $past(reg_wdata[PCC_SEL_W-1:0])))
		else $error("write not applied");

	// the bench never writes in a read's strobe cycle, so fields are current
	chk_read_timing: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && ch_hit(reg_addr, 1)) |=>
			reg_rdata == {24'h000000, lock_ff[1], on_ff[1], 2'b00, sel_ff[7:4]})
		else $error("read data wrong");

	// addresses below the channel block decode to nothing
	chk_unmapped_read_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr < PCC_CH_BASE) |=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rdata[31:8] == 24'h000000 && reg_rdata[5:4] == 2'b00)
		else $error("unused bits not zero");
	chk_no_read_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd |=> reg_rdata == 32'h00000000)
		else $error("read data without strobe");
endmodule // pcc_channel_ctrl

// ===== testbench/pcc_gen_bank.sv
`timescale 1ns/1ps
// far-side generator bank, one control byte per generator
module pcc_gen_bank (
	input wire logic core_clk,
	input wire logic [15:0] gen_lock,
	input wire logic gen_wr,
	input wire logic [3:0] gen_idx,
	input wire logic [7:0] gen_wdata,
	output logic [7:0] gen_rdata
);
	logic [7:0] ctl_ff [16] = '{default: 8'h00};
	// a locked generator keeps its value; generator zero is never held
	always @(posedge core_clk) if (gen_wr && !gen_lock[gen_idx]) ctl_ff[gen_idx] <= gen_wdata;
	assign gen_rdata = ctl_ff[gen_idx];
endmodule // pcc_gen_bank

// ===== testbench/peripheral_clock_channel_ctrl_tb_top.sv
`timescale 1ns/1ps
module peripheral_clock_channel_ctrl_tb_top;
	import pcc_pkg::*;
	logic core_clk = 0, nrst = 0, npower_rst = 0, reg_wr = 0, reg_rd = 0, gen_wr = 0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
	logic [47:0] ch_clk_on;
	logic [191:0] ch_source_select;
	logic [15:0] source_control_lock;
	logic [3:0] gen_idx = 4'h0;
	logic [7:0] gen_wdata = 8'h00, gen_rdata;
	int failures = 0, tests_run = 0;
	pcc_channel_ctrl i_dut (.core_clk(core_clk), .nrst(nrst), .npower_rst(npower_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ch_clk_on(ch_clk_on), .ch_source_select(ch_source_select),
		.source_control_lock(source_control_lock));
	pcc_gen_bank i_gen (.core_clk(core_clk), .gen_lock(source_control_lock), .gen_wr(gen_wr),
		.gen_idx(gen_idx), .gen_wdata(gen_wdata), .gen_rdata(gen_rdata));
	initial forever #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// one-cycle strobes; results are looked at 1 ns after the edge that lands them
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk) reg_wr <= 0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge core_clk) reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	// generator write; a locked generator must keep its old value
	task automatic gw(input logic [3:0] i, input logic [7:0] d, input logic [7:0] e);
		@(posedge core_clk) {gen_wr, gen_idx, gen_wdata} <= {1'b1, i, d};
		@(posedge core_clk) gen_wr <= 0;
		#1 chk("gen_ctl", 32'(e), 32'(gen_rdata));
	endtask
	task automatic t_lock;
		rd(12'h084);
		chk("ch1_reset", 32'h0, v);
		rd(12'h000);
		chk("unmapped", 32'h0, v);
		wr(12'h084, 32'hc5);
		chk("clk_on1", 32'h1, ch_clk_on[1]);
		chk("sel1", 32'h5, ch_source_select[7:4]);
		chk("gen_lock", 32'h20, source_control_lock);
		gw(4'h5, 8'h5a, 8'h00);
		wr(12'h084, 32'h0);
		rd(12'h084);
		chk("ch1_locked", 32'hc5, v);
		wr(12'h088, 32'h80);
		chk("gen0", 32'h20, source_control_lock);
		gw(4'h0, 8'h3c, 8'h3c);
		wr(12'h0bc, 32'hffff_ff7f);
		rd(12'h0bc);
		chk("ch15", 32'h4f, v);
		chk("clk_on15", 32'h1, ch_clk_on[15]);
		@(posedge core_clk) nrst <= 0;
		@(posedge core_clk) nrst <= 1;
		rd(12'h084);
		chk("ch1_sysrst", 32'hc5, v);
		chk("gen_sysrst", 32'h20, source_control_lock);
		rd(12'h0bc);
		chk("ch15_sysrst", 32'h0, v);
		$display("t_lock done");
	endtask
	task automatic t_power;
		@(posedge core_clk) {nrst, npower_rst} <= 2'b00;
		@(posedge core_clk) {nrst, npower_rst} <= 2'b11;
		#1 chk("gen_pwr", 32'h0, source_control_lock);
		wr(12'h084, 32'h43);
		rd(12'h084);
		chk("ch1_pwr", 32'h43, v);
		wr(12'h088, 32'h41);
		rd(12'h088);
		chk("ch2_pwr", 32'h41, v);
		$display("t_power done");
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		{nrst, npower_rst} <= 2'b11;
		t_lock;
		t_power;
		summarize;
	end
	initial begin
		#20000 failures++;
		summarize;
	end
endmodule // peripheral_clock_channel_ctrl_tb_top
